// [src/ffc_pkg.sv]
// Shared constants for the flag and chain-expansion FIFO block.
package ffc_pkg;
	localparam int          DATA_W        = 18;
	localparam int          OFFS_W        = 12;
	localparam int          ADDR_W        = 8;
	localparam int          PTR_W         = ADDR_W + 1;
	localparam int          CNT_W         = ADDR_W + 2;
	localparam int          MEM_DEPTH     = 256;
	localparam logic [CNT_W-1:0] DEPTH_STD  = 10'h100;
	localparam logic [CNT_W-1:0] DEPTH_FALL = 10'h101;
	localparam logic [CNT_W-1:0] HALF_LEVEL = 10'h080;
	localparam logic [ADDR_W-1:0] LAST_LOC  = 8'hFF;
	// Default offsets for the 256-deep variant.
	localparam logic [OFFS_W-1:0] EMPTY_OFFS_RST = 12'h01F;
	localparam logic [OFFS_W-1:0] FULL_OFFS_RST  = 12'h01F;
	// Strap patterns, ordered first_in_chain_n, chain_read_in_n, chain_write_in_n.
	localparam logic [2:0]  STRAP_DBL_A   = 3'h2;
	localparam logic [2:0]  STRAP_DBL_B   = 3'h6;
	localparam logic [2:0]  STRAP_FALL_A  = 3'h1;
	localparam logic [2:0]  STRAP_FALL_B  = 3'h5;
	localparam logic [2:0]  STRAP_SYNC_A  = 3'h4;
	localparam logic [2:0]  STRAP_SYNC_B  = 3'h5;
	localparam logic [2:0]  STRAP_SYNC_C  = 3'h6;
	localparam logic [2:0]  STRAP_CHAIN_A = 3'h3;
	localparam logic [2:0]  STRAP_CHAIN_B = 3'h7;
	// Register map, byte addresses.
	localparam logic [3:0]  REG_EMPTY_OFFS = 4'h0;
	localparam logic [3:0]  REG_FULL_OFFS  = 4'h4;
	localparam logic [3:0]  REG_STATUS     = 4'h8;
	localparam logic [3:0]  REG_LEVEL      = 4'hC;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	// Status register bit positions.
	localparam int          ST_EMPTY_N    = 0;
	localparam int          ST_FULL_N     = 1;
	localparam int          ST_AEMPTY_N   = 2;
	localparam int          ST_AFULL_N    = 3;
	localparam int          ST_HALF_N     = 4;
	localparam int          ST_OUT_RDY_N  = 5;
	localparam int          ST_IN_RDY_N   = 6;
	localparam int          ST_FALL_MODE  = 8;
	localparam int          ST_DOUBLE_BUF = 9;
	localparam int          ST_SYNC_FLAGS = 10;
	localparam int          ST_CHAIN_MODE = 11;
	localparam int          ST_WR_OWNER   = 12;
	localparam int          ST_RD_OWNER   = 13;
endpackage : ffc_pkg

// [src/ffc_top.sv]
// FIFO core with status flags, chain expansion and an AXI4-Lite register slave.
// Behaviour
// - standard mode: almost empty at count <= n
// - fall-through: almost empty at count <= n+1
// - default empty offset 31 for 256 words
// - async almost empty: read sets, write clears
// - sync almost empty changes on read ticks
// - half full asserts on next write tick
// - half full releases on read tick
// - shared output is half full unless chained
// - pulse chain write out at last location
// - pulse chain read out at last location
// - data out is 18 bits wide
// - after reset data out zero, drive per enable
// - input ready first low on write tick
// - full flag single or double buffered
// - empty flag single or double buffered
// - standard first word read after empty deasserts
// - empty deassert within one or two reads
// - async almost full: write sets, read clears
// - output ready three read ticks after write
// - sync almost empty may slip one tick
// - fall-through depth is one word more
// - almost full from full offset register
// - two 12-bit offset registers, pin loadable
module ffc_top (
	// Clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         srst,
	// Write port, wr_tick marks a write clock edge
	input  wire logic                         wr_tick,
	input  wire logic                         write_en_n,
	input  wire logic [ffc_pkg::DATA_W-1:0]   data_in,
	// Read port, rd_tick marks a read clock edge
	input  wire logic                         rd_tick,
	input  wire logic                         read_en_n,
	input  wire logic                         output_drive_en_n,
	input  wire logic                         offset_program_n,
	output logic      [ffc_pkg::DATA_W-1:0]   data_out,
	output logic                              data_out_oe,
	// Straps and chain links
	input  wire logic                         first_in_chain_n,
	input  wire logic                         chain_read_in_n,
	input  wire logic                         chain_write_in_n,
	output logic                              chain_write_out_n,
	output logic                              chain_read_out_n,
	// Flags
	output logic                              empty_n,
	output logic                              output_ready_n,
	output logic                              full_n,
	output logic                              input_ready_n,
	output logic                              almost_empty_n,
	output logic                              almost_full_n,
	// AXI4-Lite slave
	input  wire logic [3:0]                   s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic      [1:0]                   s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [3:0]                   s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic      [31:0]                  s_axi_rdata,
	output logic      [1:0]                   s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready
);
	logic [ffc_pkg::DATA_W-1:0] mem [ffc_pkg::MEM_DEPTH];
	logic [ffc_pkg::PTR_W-1:0]  wptr;
	logic [ffc_pkg::PTR_W-1:0]  rptr;
	logic [ffc_pkg::OFFS_W-1:0] empty_offs;
	logic [ffc_pkg::OFFS_W-1:0] full_offs;
	logic                       prog_wsel, prog_rsel, fall_mode, double_buf, sync_flags, chain_mode;
	logic                       wr_owner, rd_owner, empty_stage, full_stage, seen_stage, mem_seen, out_valid, half_n;
	logic [2:0]                 strap;
	logic [ffc_pkg::CNT_W-1:0]  mem_count, total, depth, af_level;
	logic [ffc_pkg::OFFS_W:0]   ae_level;
	logic                       wr_fire, rd_fire, load_out, prog_wr, prog_rd, ae_cond, af_cond;
	logic                       next_mem_nonempty, next_mem_full;
	logic [3:0]                 aw_addr;
	logic [31:0]                w_data;
	logic                       aw_held, w_held, bus_wr, bus_wr_empty, bus_wr_full;

	assign strap = {first_in_chain_n, chain_read_in_n, chain_write_in_n};

	// Mode selection is held from the last cycle of reset onward.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			fall_mode  <= (strap == ffc_pkg::STRAP_FALL_A) || (strap == ffc_pkg::STRAP_FALL_B);
			double_buf <= (strap == ffc_pkg::STRAP_DBL_A) || (strap == ffc_pkg::STRAP_DBL_B);
			sync_flags <= (strap == ffc_pkg::STRAP_SYNC_A) || (strap == ffc_pkg::STRAP_SYNC_B) ||
			              (strap == ffc_pkg::STRAP_SYNC_C);
			chain_mode <= (strap == ffc_pkg::STRAP_CHAIN_A) || (strap == ffc_pkg::STRAP_CHAIN_B);
		end
	end

	// Fill levels; in fall-through mode the output register counts as one more word.
	assign mem_count = {1'b0, wptr - rptr};
	assign total     = mem_count + {{(ffc_pkg::CNT_W-1){1'b0}}, fall_mode & out_valid};
	assign depth     = fall_mode ? ffc_pkg::DEPTH_FALL : ffc_pkg::DEPTH_STD;
	assign af_level  = depth - full_offs[ffc_pkg::CNT_W-1:0];
	assign ae_level  = {1'b0, empty_offs} + {{ffc_pkg::OFFS_W{1'b0}}, fall_mode};
	assign ae_cond   = {3'h0, total} <= ae_level;
	assign af_cond   = total >= af_level;

	// Port qualification. Each side is gated by its own flag register, so a word
	// becomes visible to the reader only after the flag path has caught up.
	assign prog_wr  = wr_tick && !write_en_n && !offset_program_n;
	assign prog_rd  = rd_tick && !read_en_n && !offset_program_n && !fall_mode;
	assign wr_fire  = wr_tick && !write_en_n && offset_program_n && wr_owner &&
	                  (fall_mode ? !input_ready_n : full_n);
	assign load_out = fall_mode && rd_tick && mem_seen && rd_owner && (!out_valid || !read_en_n);
	assign rd_fire  = (!fall_mode && rd_tick && !read_en_n && offset_program_n && rd_owner && empty_n)
	                  || load_out;
	assign next_mem_nonempty = (mem_count - {{(ffc_pkg::CNT_W-1){1'b0}}, rd_fire}) != '0;
	assign next_mem_full     = (mem_count + {{(ffc_pkg::CNT_W-1){1'b0}}, wr_fire}) >= ffc_pkg::DEPTH_STD;

	always_ff @(posedge core_clk) begin
		if (wr_fire) begin
			mem[wptr[ffc_pkg::ADDR_W-1:0]] <= data_in;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			wptr <= '0;
			rptr <= '0;
		end else begin
			if (wr_fire) begin
				wptr <= wptr + 1'b1;
			end
			if (rd_fire) begin
				rptr <= rptr + 1'b1;
			end
		end
	end

	// Chain ownership: every device owns both sides after reset, whatever first_in_chain_n says.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_owner          <= 1'b1;
			rd_owner          <= 1'b1;
			chain_write_out_n <= 1'b1;
			chain_read_out_n  <= 1'b1;
		end else if (chain_mode) begin
			chain_write_out_n <= !(wr_fire && wptr[ffc_pkg::ADDR_W-1:0] == ffc_pkg::LAST_LOC);
			chain_read_out_n  <= !(rd_fire && rptr[ffc_pkg::ADDR_W-1:0] == ffc_pkg::LAST_LOC);
			if (wr_fire && wptr[ffc_pkg::ADDR_W-1:0] == ffc_pkg::LAST_LOC) begin
				wr_owner <= 1'b0;
			end else if (!chain_write_in_n) begin
				wr_owner <= 1'b1;
			end
			if (rd_fire && rptr[ffc_pkg::ADDR_W-1:0] == ffc_pkg::LAST_LOC) begin
				rd_owner <= 1'b0;
			end else if (!chain_read_in_n) begin
				rd_owner <= 1'b1;
			end
		end else begin
			chain_write_out_n <= half_n;
			chain_read_out_n  <= 1'b1;
			wr_owner          <= 1'b1;
			rd_owner          <= 1'b1;
		end
	end

	// Empty side: double buffering delays only the release, never the assertion.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			empty_stage    <= 1'b0;
			empty_n        <= 1'b0;
			seen_stage     <= 1'b0;
			mem_seen       <= 1'b0;
			out_valid      <= 1'b0;
			output_ready_n <= 1'b1;
		end else if (rd_tick) begin
			empty_stage <= next_mem_nonempty;
			if (!fall_mode) begin
				empty_n <= double_buf ? (empty_stage && next_mem_nonempty) : next_mem_nonempty;
			end else begin
				seen_stage <= next_mem_nonempty;
				mem_seen   <= next_mem_nonempty && (seen_stage || mem_seen);
				if (load_out) begin
					out_valid      <= 1'b1;
					output_ready_n <= 1'b0;
				end else if (!read_en_n && out_valid) begin
					out_valid      <= 1'b0;
					output_ready_n <= 1'b1;
				end
			end
		end
	end

	// Full side; input ready is only driven low from the first write tick after reset.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			full_stage    <= 1'b1;
			full_n        <= 1'b1;
			input_ready_n <= 1'b1;
		end else if (wr_tick) begin
			full_stage <= !next_mem_full;
			if (fall_mode) begin
				input_ready_n <= next_mem_full;
			end else begin
				full_n <= double_buf ? (full_stage && !next_mem_full) : !next_mem_full;
			end
		end
	end

	// Programmable flags and half full.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			almost_empty_n <= 1'b0;
			almost_full_n  <= 1'b1;
			half_n         <= 1'b1;
		end else begin
			if (sync_flags) begin
				if (rd_tick) begin
					almost_empty_n <= !ae_cond;
				end
				if (wr_tick) begin
					almost_full_n <= !af_cond;
				end
			end else begin
				if (rd_tick && ae_cond) begin
					almost_empty_n <= 1'b0;
				end else if (wr_tick && !ae_cond) begin
					almost_empty_n <= 1'b1;
				end
				if (wr_tick && af_cond) begin
					almost_full_n <= 1'b0;
				end else if (rd_tick && !af_cond) begin
					almost_full_n <= 1'b1;
				end
			end
			if (wr_fire && mem_count >= ffc_pkg::HALF_LEVEL) begin
				half_n <= 1'b0;
			end else if (rd_tick && mem_count <= ffc_pkg::HALF_LEVEL) begin
				half_n <= 1'b1;
			end
		end
	end

	// Output register and drive enable.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			data_out    <= '0;
			data_out_oe <= 1'b0;
			prog_rsel   <= 1'b0;
		end else begin
			data_out_oe <= !output_drive_en_n;
			if (prog_rd) begin
				data_out  <= {{(ffc_pkg::DATA_W-ffc_pkg::OFFS_W){1'b0}}, prog_rsel ? full_offs : empty_offs};
				prog_rsel <= !prog_rsel;
			end else if (rd_fire) begin
				data_out <= mem[rptr[ffc_pkg::ADDR_W-1:0]];
			end
		end
	end

	// Offset registers, loaded from the data pins or from the bus; the bus wins a tie.
	assign bus_wr       = aw_held && w_held && !s_axi_bvalid;
	assign bus_wr_empty = bus_wr && aw_addr == ffc_pkg::REG_EMPTY_OFFS;
	assign bus_wr_full  = bus_wr && aw_addr == ffc_pkg::REG_FULL_OFFS;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			empty_offs <= ffc_pkg::EMPTY_OFFS_RST;
			full_offs  <= ffc_pkg::FULL_OFFS_RST;
			prog_wsel  <= 1'b0;
		end else begin
			if (prog_wr) begin
				prog_wsel <= !prog_wsel;
			end
			if (bus_wr_empty) begin
				empty_offs <= w_data[ffc_pkg::OFFS_W-1:0];
			end else if (prog_wr && !prog_wsel) begin
				empty_offs <= data_in[ffc_pkg::OFFS_W-1:0];
			end
			if (bus_wr_full) begin
				full_offs <= w_data[ffc_pkg::OFFS_W-1:0];
			end else if (prog_wr && prog_wsel) begin
				full_offs <= data_in[ffc_pkg::OFFS_W-1:0];
			end
		end
	end

	// AXI4-Lite write channels, taken in either order.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= ffc_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (bus_wr) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (bus_wr_empty || bus_wr_full) ? ffc_pkg::RESP_OKAY : ffc_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= ffc_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= ffc_pkg::RESP_OKAY;
				s_axi_rdata  <= '0;
				case (s_axi_araddr)
					ffc_pkg::REG_EMPTY_OFFS: s_axi_rdata <= {20'h00000, empty_offs};
					ffc_pkg::REG_FULL_OFFS:  s_axi_rdata <= {20'h00000, full_offs};
					ffc_pkg::REG_LEVEL:      s_axi_rdata <= {22'h000000, total};
					ffc_pkg::REG_STATUS: begin
						s_axi_rdata[ffc_pkg::ST_EMPTY_N]    <= empty_n;
						s_axi_rdata[ffc_pkg::ST_FULL_N]     <= full_n;
						s_axi_rdata[ffc_pkg::ST_AEMPTY_N]   <= almost_empty_n;
						s_axi_rdata[ffc_pkg::ST_AFULL_N]    <= almost_full_n;
						s_axi_rdata[ffc_pkg::ST_HALF_N]     <= half_n;
						s_axi_rdata[ffc_pkg::ST_OUT_RDY_N]  <= output_ready_n;
						s_axi_rdata[ffc_pkg::ST_IN_RDY_N]   <= input_ready_n;
						s_axi_rdata[ffc_pkg::ST_FALL_MODE]  <= fall_mode;
						s_axi_rdata[ffc_pkg::ST_DOUBLE_BUF] <= double_buf;
						s_axi_rdata[ffc_pkg::ST_SYNC_FLAGS] <= sync_flags;
						s_axi_rdata[ffc_pkg::ST_CHAIN_MODE] <= chain_mode;
						s_axi_rdata[ffc_pkg::ST_WR_OWNER]   <= wr_owner;
						s_axi_rdata[ffc_pkg::ST_RD_OWNER]   <= rd_owner;
					end
					default: s_axi_rresp <= ffc_pkg::RESP_SLVERR;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : ffc_top

// [verif/ffc_checker.sv]
// Port-level timing checks for the FIFO flag and chain-expansion block.
module ffc_checker (
	// Clock and reset
	input  wire logic  core_clk,
	input  wire logic  srst,
	// Port ticks and straps
	input  wire logic  wr_tick,
	input  wire logic  rd_tick,
	input  wire logic  first_in_chain_n,
	input  wire logic  chain_read_in_n,
	input  wire logic  chain_write_in_n,
	// Watched outputs
	input  wire logic  chain_write_out_n,
	input  wire logic  chain_read_out_n,
	input  wire logic  empty_n,
	input  wire logic  full_n,
	input  wire logic  output_ready_n,
	input  wire logic  input_ready_n,
	input  wire logic  almost_empty_n,
	input  wire logic  almost_full_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0]  strap;
	logic        sync_m, fall_m, chain_m;
	// The mode is known only from the straps seen while reset is high.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			strap <= {first_in_chain_n, chain_read_in_n, chain_write_in_n};
		end
	end
	assign sync_m  = strap == ffc_pkg::STRAP_SYNC_A || strap == ffc_pkg::STRAP_SYNC_B || strap == ffc_pkg::STRAP_SYNC_C;
	assign fall_m  = strap == ffc_pkg::STRAP_FALL_A || strap == ffc_pkg::STRAP_FALL_B;
	assign chain_m = strap == ffc_pkg::STRAP_CHAIN_A || strap == ffc_pkg::STRAP_CHAIN_B;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	a_ae_async_edges: assert property (!sync_m && $changed(almost_empty_n) |->
		(almost_empty_n ? $past(wr_tick) : $past(rd_tick))) else $error("almost empty moved on a wrong tick");
	a_ae_sync_edges: assert property (sync_m && $changed(almost_empty_n) |-> $past(rd_tick))
		else $error("synchronous almost empty moved off a read tick");
	a_af_async_edges: assert property (!sync_m && $changed(almost_full_n) |->
		(almost_full_n ? $past(rd_tick) : $past(wr_tick))) else $error("almost full moved on a wrong tick");
	a_hf_set_edge: assert property (!chain_m && $fell(chain_write_out_n) |-> $past(wr_tick, 2))
		else $error("half full set off a write tick");
	a_hf_clr_edge: assert property (!chain_m && $rose(chain_write_out_n) |-> $past(rd_tick, 2))
		else $error("half full cleared off a read tick");
	a_wchain_pulse: assert property (chain_m && $fell(chain_write_out_n) |=> chain_write_out_n)
		else $error("write chain pulse too long");
	a_rchain_pulse: assert property (chain_m && $fell(chain_read_out_n) |=> chain_read_out_n)
		else $error("read chain pulse too long");
	a_rchain_idle: assert property (!chain_m |-> chain_read_out_n)
		else $error("read chain output active outside chain mode");
	a_empty_rd_edge: assert property (!fall_m && $rose(empty_n) |-> $past(rd_tick))
		else $error("empty flag released off a read tick");
	a_full_wr_edge: assert property (!fall_m && $rose(full_n) |-> $past(wr_tick))
		else $error("full flag released off a write tick");
	a_ir_wr_edge: assert property (fall_m && $fell(input_ready_n) |-> $past(wr_tick))
		else $error("input ready set off a write tick");
	a_or_rd_edge: assert property (fall_m && $fell(output_ready_n) |-> $past(rd_tick))
		else $error("output ready set off a read tick");
endmodule : ffc_checker

bind ffc_top ffc_checker ffc_checker_i (.core_clk(core_clk), .srst(srst), .wr_tick(wr_tick), .rd_tick(rd_tick),
	.first_in_chain_n(first_in_chain_n), .chain_read_in_n(chain_read_in_n), .chain_write_in_n(chain_write_in_n),
	.chain_write_out_n(chain_write_out_n), .chain_read_out_n(chain_read_out_n), .empty_n(empty_n), .full_n(full_n),
	.output_ready_n(output_ready_n), .input_ready_n(input_ready_n), .almost_empty_n(almost_empty_n),
	.almost_full_n(almost_full_n));

// [verif/ffc_port_model.sv]
// Free-running write and read port ticks and static strap levels for the FIFO block.
module ffc_port_model #(
	parameter int WR_DIV = 3,
	parameter int RD_DIV = 4
) (
	// Clock and chosen strap pattern
	input  wire logic        core_clk,
	input  wire logic [2:0]  mode_sel,
	// Towards the block
	output logic             wr_tick,
	output logic             rd_tick,
	output logic             first_in_chain_n,
	output logic             chain_read_in_n,
	output logic             chain_write_in_n
);
	timeunit 1ns;
	timeprecision 1ns;
	int wr_cnt = 0;
	int rd_cnt = 0;
	// Unequal dividers keep the two port clocks sliding against each other.
	always @(posedge core_clk) begin
		wr_cnt <= (wr_cnt == WR_DIV - 1) ? 0 : wr_cnt + 1;
		rd_cnt <= (rd_cnt == RD_DIV - 1) ? 0 : rd_cnt + 1;
	end
	assign wr_tick = wr_cnt == 0;
	assign rd_tick = rd_cnt == 0;
	assign {first_in_chain_n, chain_read_in_n, chain_write_in_n} = mode_sel;
endmodule : ffc_port_model

// [verif/tb_ffc_top.sv]
// Self-checking bench for the FIFO flag and chain-expansion block.
module tb_ffc_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk, srst, wr_tick, rd_tick, write_en_n, read_en_n, output_drive_en_n, offset_program_n;
	logic [17:0] data_in, data_out;
	logic        data_out_oe, first_in_chain_n, chain_read_in_n, chain_write_in_n, chain_write_out_n;
	logic        chain_read_out_n, empty_n, output_ready_n, full_n, input_ready_n, almost_empty_n, almost_full_n;
	logic [3:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [2:0]  mode_sel;
	int          failures, compares, wpulses, rpulses;
	ffc_top ffc_top_i (.core_clk(core_clk), .srst(srst), .wr_tick(wr_tick), .write_en_n(write_en_n),
		.data_in(data_in), .rd_tick(rd_tick), .read_en_n(read_en_n), .output_drive_en_n(output_drive_en_n),
		.offset_program_n(offset_program_n), .data_out(data_out), .data_out_oe(data_out_oe),
		.first_in_chain_n(first_in_chain_n), .chain_read_in_n(chain_read_in_n), .chain_write_in_n(chain_write_in_n),
		.chain_write_out_n(chain_write_out_n), .chain_read_out_n(chain_read_out_n), .empty_n(empty_n),
		.output_ready_n(output_ready_n), .full_n(full_n), .input_ready_n(input_ready_n),
		.almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	ffc_port_model ffc_port_model_i (.core_clk(core_clk), .mode_sel(mode_sel), .wr_tick(wr_tick), .rd_tick(rd_tick),
		.first_in_chain_n(first_in_chain_n), .chain_read_in_n(chain_read_in_n), .chain_write_in_n(chain_write_in_n));
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// Chain pulses last one cycle, so low samples count pulses.
	always @(negedge core_clk) begin
		if (chain_write_out_n === 1'b0) wpulses++;
		if (chain_read_out_n === 1'b0) rpulses++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : settle
	task automatic do_reset(input logic [2:0] m);
		@(posedge core_clk);
		srst     <= 1'b1;
		mode_sel <= m;
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		@(negedge core_clk);
	endtask : do_reset
	// One port access; the request is held until the matching port tick takes it.
	task automatic fifo_op(input logic wr, input logic prog, input logic [17:0] d);
		@(posedge core_clk);
		offset_program_n <= !prog;
		write_en_n       <= !wr;
		read_en_n        <= wr;
		data_in          <= d;
		do @(posedge core_clk); while ((wr ? wr_tick : rd_tick) !== 1'b1);
		write_en_n       <= 1'b1;
		read_en_n        <= 1'b1;
		offset_program_n <= 1'b1;
		@(negedge core_clk);
	endtask : fifo_op
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, ffc_pkg::RESP_OKAY);
	endtask : axi_wr
	task automatic axi_chk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] rsp, input logic [31:0] msk);
		@(posedge core_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata & msk, exp);
		chk(s_axi_rresp, rsp);
	endtask : axi_chk
	task automatic stream(input int n, input logic [17:0] base);
		for (int i = 0; i < n; i++) fifo_op(1'b1, 1'b0, base + 18'(i));
		settle(12);
		for (int i = 0; i < n; i++) begin
			fifo_op(1'b0, 1'b0, 18'h00000);
			settle(1);
			chk(data_out, base + 18'(i));
		end
	endtask : stream
	task automatic tally_and_finish();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#3000000;
		failures++;
		$display("Error at %0t: watchdog expired", $time);
		tally_and_finish();
	end
	initial begin
		{srst, write_en_n, read_en_n, offset_program_n} = 4'hF;
		{output_drive_en_n, data_in, mode_sel, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{failures, compares, wpulses, rpulses} = '0;
		do_reset(3'h0);
		chk({data_out, data_out_oe, empty_n, full_n, almost_empty_n, almost_full_n}, 32'h00005);
		chk({chain_write_out_n, chain_read_out_n}, 2'h3);
		settle(2);
		chk(data_out_oe, 1'b1);
		axi_chk(ffc_pkg::REG_EMPTY_OFFS, 32'h01F, ffc_pkg::RESP_OKAY, 32'hFFFFFFFF);
		axi_chk(ffc_pkg::REG_FULL_OFFS, 32'h01F, ffc_pkg::RESP_OKAY, 32'hFFFFFFFF);
		axi_chk(4'h2, 32'h0, ffc_pkg::RESP_SLVERR, 32'hFFFFFFFF);
		$display("reset test done");
		fifo_op(1'b1, 1'b1, 18'h00006);
		axi_chk(ffc_pkg::REG_EMPTY_OFFS, 32'h006, ffc_pkg::RESP_OKAY, 32'hFFFFFFFF);
		fifo_op(1'b0, 1'b1, 18'h00000);
		settle(1);
		chk(data_out, 18'h00006);
		axi_wr(ffc_pkg::REG_EMPTY_OFFS, 32'h004);
		for (int i = 0; i < 5; i++) begin
			fifo_op(1'b1, 1'b0, 18'h2A000 + 18'(i));
			settle(4);
			chk(almost_empty_n, i == 4);
		end
		settle(8);
		chk(empty_n, 1'b1);
		for (int i = 0; i < 5; i++) begin
			fifo_op(1'b0, 1'b0, 18'h00000);
			settle(5);
			chk(data_out, 18'h2A000 + 18'(i));
			chk(almost_empty_n, 1'b0);
		end
		chk(empty_n, 1'b0);
		$display("offset test done");
		for (int i = 1; i <= 257; i++) begin
			fifo_op(1'b1, 1'b0, 18'(i * 5));
			settle(4);
			if (i == 128 || i == 129) chk(chain_write_out_n, i == 128);
			if (i == 224 || i == 225) chk(almost_full_n, i == 224);
			if (i >= 255) chk(full_n, i < 256);
		end
		axi_chk(ffc_pkg::REG_LEVEL, 32'h100, ffc_pkg::RESP_OKAY, 32'h3FF);
		for (int i = 1; i <= 256; i++) begin
			fifo_op(1'b0, 1'b0, 18'h00000);
			settle(6);
			chk(data_out, 18'(i * 5));
			if (i == 1) chk(full_n, 1'b1);
			if (i == 127 || i == 128) chk(chain_write_out_n, i == 128);
		end
		$display("fill test done");
		do_reset(ffc_pkg::STRAP_FALL_A);
		settle(6);
		chk({input_ready_n, output_ready_n}, 2'h1);
		for (int i = 1; i <= 257; i++) begin
			fifo_op(1'b1, 1'b0, 18'h10000 + 18'(i));
			settle(i == 1 ? 16 : 4);
			if (i == 1) chk({output_ready_n, data_out}, 19'h10001);
			if (i == 32 || i == 33) chk(almost_empty_n, i == 33);
			if (i >= 256) chk(input_ready_n, i == 257);
		end
		axi_chk(ffc_pkg::REG_LEVEL, 32'h101, ffc_pkg::RESP_OKAY, 32'h3FF);
		$display("fall-through test done");
		do_reset(ffc_pkg::STRAP_SYNC_A);
		settle(2);
		axi_chk(ffc_pkg::REG_STATUS, 32'h400, ffc_pkg::RESP_OKAY, 32'hF00);
		stream(40, 18'h22000);
		do_reset(ffc_pkg::STRAP_DBL_A);
		stream(3, 18'h3F000);
		$display("sync and double test done");
		do_reset(ffc_pkg::STRAP_CHAIN_A);
		{wpulses, rpulses} = '0;
		stream(256, 18'h05000);
		chk(wpulses, 1);
		chk(rpulses, 1);
		$display("chain test done");
		tally_and_finish();
	end
endmodule : tb_ffc_top
